// ==== src/gpio_pkg.sv ====
// Shared constants, register map and types of the three-port pin block.
package gpio_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W  = 32;
   localparam int OFF_W   = 12;
   localparam int WIDTH_A = 6;
   localparam int WIDTH_B = 8;
   localparam int WIDTH_C = 4;

   // ****************************************
   // Port windows, selected by byte address bits 13:12
   // ****************************************
   localparam logic [1:0] SEL_PORT_A = 2'h0;
   localparam logic [1:0] SEL_PORT_B = 2'h1;
   localparam logic [1:0] SEL_PORT_C = 2'h2;

   // ****************************************
   // Byte offsets inside one port window
   // ****************************************
   localparam logic [1:0]       DATA_REGION  = 2'h0;
   localparam logic [OFF_W-1:0] OFF_DIR      = 12'h400;
   localparam logic [OFF_W-1:0] OFF_ISENSE   = 12'h404;
   localparam logic [OFF_W-1:0] OFF_IBOTH    = 12'h408;
   localparam logic [OFF_W-1:0] OFF_IEVENT   = 12'h40C;
   localparam logic [OFF_W-1:0] OFF_IMASK    = 12'h410;
   localparam logic [OFF_W-1:0] OFF_IRAW     = 12'h414;
   localparam logic [OFF_W-1:0] OFF_IMASKED  = 12'h418;
   localparam logic [OFF_W-1:0] OFF_ICLEAR   = 12'h41C;
   localparam logic [OFF_W-1:0] OFF_ALTSEL   = 12'h420;
   localparam logic [OFF_W-1:0] OFF_PULLDN   = 12'h424;
   localparam logic [OFF_W-1:0] OFF_PULLUP   = 12'h428;
   localparam logic [OFF_W-1:0] OFF_DIGEN    = 12'h42C;
   localparam logic [OFF_W-1:0] OFF_MUXCTL   = 12'h430;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [WIDTH_A-1:0]   RST_A_ALT   = 6'h3F;
   localparam logic [WIDTH_A-1:0]   RST_A_DIGEN = 6'h3F;
   localparam logic [WIDTH_A-1:0]   RST_A_PULL  = 6'h00;
   localparam logic [4*WIDTH_A-1:0] RST_A_MUX   = 24'h111111;
   localparam logic [WIDTH_B-1:0]   RST_B_ZERO  = 8'h00;
   localparam logic [4*WIDTH_B-1:0] RST_B_MUX   = 32'h00000000;
   localparam logic [WIDTH_C-1:0]   RST_C_ALT   = 4'hF;
   localparam logic [WIDTH_C-1:0]   RST_C_DIGEN = 4'hF;
   localparam logic [WIDTH_C-1:0]   RST_C_PULLD = 4'h0;
   localparam logic [WIDTH_C-1:0]   RST_C_PULLU = 4'hF;
   localparam logic [4*WIDTH_C-1:0] RST_C_MUX   = 16'h3333;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic              en;
      logic [OFF_W-1:0]  off;
      logic [DATA_W-1:0] data;
   } reg_wr_t;

   typedef enum logic {ST_IDLE, ST_DATA} bus_state_t;

endpackage : gpio_pkg

// ==== src/gpio_ports_with_pin_mux.sv ====
// Three identical pin ports with pin mux, interrupts and an AHB-Lite register slave.
//
// Notes on behaviour
// (RQ1) Three identical port instances A, B, C.
// (RQ2) Port widths six, eight and four pins.
// (RQ3) Output may toggle every two clocks.
// (RQ4) Per-pin mask gates interrupt output.
// (RQ5) Edge detect: rising, falling or both.
// (RQ6) Level detect: high or low level.
// (RQ7) Data access masked by address bits.
// (RQ8) Mask is address 9:2, reads zero elsewhere.
// (RQ9) Digital enable off disconnects digital path.
// (RQ10) Alternate function needs select plus enable.
// (RQ11) Pin configuration independent for every pin.
// (RQ12) Default: software mode, tri-stated, all zero.
// (RQ13) Reset restores every pin default.
// (RQ14) Port A resets to alternate, code one.
// (RQ15) Port C resets alternate, pull-up, code three.
// (RQ16) Fixed pin-to-peripheral function mapping.
// (RQ17) Direction selects input capture or drive.
// (RQ18) One interrupt per port; edges sticky.
// (RQ19) Pin inputs pass two sync flops.
// (RQ20) Software configures mux before peripheral use.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module gpio_port
   import gpio_pkg::*;
#(
   parameter int                   WIDTH     = 8,
   parameter logic [WIDTH-1:0]     ALT_RST   = '0,
   parameter logic [WIDTH-1:0]     DIGEN_RST = '0,
   parameter logic [WIDTH-1:0]     PULLD_RST = '0,
   parameter logic [WIDTH-1:0]     PULLU_RST = '0,
   parameter logic [4*WIDTH-1:0]   MUX_RST   = '0
) (
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // Register access
   input  wire reg_wr_t              wr,
   input  wire logic [OFF_W-1:0]     rd_off,
   output logic      [DATA_W-1:0]    rdata,
   // Pads
   input  wire logic [WIDTH-1:0]     pad_in,
   output logic      [WIDTH-1:0]     pad_out_ff,
   output logic      [WIDTH-1:0]     pad_oe_ff,
   output logic      [WIDTH-1:0]     pull_up_enable_ff,
   output logic      [WIDTH-1:0]     pull_down_enable_ff,
   output logic      [WIDTH-1:0]     digital_enable_reg_ff,
   // Peripherals
   input  wire logic [WIDTH-1:0]     alt_out,
   input  wire logic [WIDTH-1:0]     alt_oe,
   output logic      [WIDTH-1:0]     alt_in_ff,
   output logic      [4*WIDTH-1:0]   port_mux_control_ff,
   // Interrupt
   output logic                      irq_ff
);

   // ****************************************
   // Decode
   // ****************************************
   function automatic logic hit(input reg_wr_t w, input logic [OFF_W-1:0] o);
      return w.en && (w.off == o);
   endfunction : hit

   logic [WIDTH-1:0] meta_ff, sync_ff, prev_ff;
   logic [WIDTH-1:0] pin_data_reg_ff, direction_reg_ff, alt_function_select_ff;
   logic [WIDTH-1:0] isense_ff, iboth_ff, ievent_ff, imask_ff, iraw_ff;
   logic [WIDTH-1:0] wmask, rmask, wval, clr, rise, fall, edge_evt, lvl_evt, nxt_iraw;
   logic [7:0]       wsel, rsel;
   logic             data_wr;

   // (RQ8) Address mask bits.
   assign wsel    = wr.off[9:2];
   assign rsel    = rd_off[9:2];
   assign wmask   = wsel[WIDTH-1:0];
   assign rmask   = rsel[WIDTH-1:0];
   assign wval    = wr.data[WIDTH-1:0];
   assign data_wr = wr.en && (wr.off[11:10] == DATA_REGION);

   // ****************************************
   // Input synchroniser
   // ****************************************
   // (RQ19) Two flops before use.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= pad_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // ****************************************
   // Data register
   // ****************************************
   // (RQ17) Capture inputs, hold outputs.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_data_reg_ff <= '0;
      end else begin
         pin_data_reg_ff <= (direction_reg_ff & (data_wr ? ((wval & wmask) | (pin_data_reg_ff & ~wmask))
                                                         : pin_data_reg_ff))
                          | (~direction_reg_ff & sync_ff & digital_enable_reg_ff);
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   // (RQ12) Zero defaults, per-port parameter defaults for alternate, enable, pulls and mux; (RQ13) reset restores them.
   // (RQ11) Every pin has its own bit; a write loads the whole register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         direction_reg_ff       <= '0;
         isense_ff              <= '0;
         iboth_ff               <= '0;
         ievent_ff              <= '0;
         imask_ff               <= '0;
         alt_function_select_ff <= ALT_RST;
         digital_enable_reg_ff  <= DIGEN_RST;
         pull_down_enable_ff    <= PULLD_RST;
         pull_up_enable_ff      <= PULLU_RST;
         port_mux_control_ff    <= MUX_RST;
      end else begin
         if (hit(wr, OFF_DIR))    direction_reg_ff       <= wval;
         if (hit(wr, OFF_ISENSE)) isense_ff              <= wval;
         if (hit(wr, OFF_IBOTH))  iboth_ff               <= wval;
         if (hit(wr, OFF_IEVENT)) ievent_ff              <= wval;
         if (hit(wr, OFF_IMASK))  imask_ff               <= wval;
         if (hit(wr, OFF_ALTSEL)) alt_function_select_ff <= wval;
         if (hit(wr, OFF_DIGEN))  digital_enable_reg_ff  <= wval;
         if (hit(wr, OFF_PULLDN)) pull_down_enable_ff    <= wval;
         if (hit(wr, OFF_PULLUP)) pull_up_enable_ff      <= wval;
         if (hit(wr, OFF_MUXCTL)) port_mux_control_ff    <= wr.data[4*WIDTH-1:0];
      end
   end

   // ****************************************
   // Interrupt detection
   // ****************************************
   assign rise     = sync_ff & ~prev_ff;
   assign fall     = ~sync_ff & prev_ff;
   // (RQ5) Edge kinds per pin.
   assign edge_evt = digital_enable_reg_ff & ~isense_ff
                   & ((iboth_ff & (rise | fall)) | (~iboth_ff & ievent_ff & rise) | (~iboth_ff & ~ievent_ff & fall));
   // (RQ6) Level polarity per pin.
   assign lvl_evt  = digital_enable_reg_ff & isense_ff & ~(ievent_ff ^ sync_ff);
   assign clr      = hit(wr, OFF_ICLEAR) ? wval : '0;
   // (RQ18) Sticky edges; an event beats a clear in the same cycle.
   assign nxt_iraw = (iraw_ff & ~clr & ~isense_ff) | edge_evt | lvl_evt;

   // (RQ4) Mask gates the port interrupt.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         iraw_ff <= '0;
         irq_ff  <= 1'b0;
      end else begin
         iraw_ff <= nxt_iraw;
         irq_ff  <= |(nxt_iraw & imask_ff);
      end
   end

   // ****************************************
   // Pad and peripheral routing
   // ****************************************
   // (RQ10) Peripheral owns pin only with select and enable.
   // (RQ9) Disabled pins neither drive nor feed logic.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_out_ff <= '0;
         pad_oe_ff  <= '0;
         alt_in_ff  <= '0;
      end else begin
         pad_out_ff <= (alt_function_select_ff & alt_out) | (~alt_function_select_ff & pin_data_reg_ff);
         pad_oe_ff  <= digital_enable_reg_ff
                     & ((alt_function_select_ff & alt_oe) | (~alt_function_select_ff & direction_reg_ff));
         alt_in_ff  <= sync_ff & digital_enable_reg_ff & alt_function_select_ff;
      end
   end

   // ****************************************
   // Read mux
   // ****************************************
   // (RQ7) Masked data read.
   always_comb begin
      rdata = '0;
      if (rd_off[11:10] == DATA_REGION) begin
         rdata = DATA_W'(pin_data_reg_ff & rmask);
      end else begin
         unique case (rd_off)
            OFF_DIR:     rdata = DATA_W'(direction_reg_ff);
            OFF_ISENSE:  rdata = DATA_W'(isense_ff);
            OFF_IBOTH:   rdata = DATA_W'(iboth_ff);
            OFF_IEVENT:  rdata = DATA_W'(ievent_ff);
            OFF_IMASK:   rdata = DATA_W'(imask_ff);
            OFF_IRAW:    rdata = DATA_W'(iraw_ff);
            OFF_IMASKED: rdata = DATA_W'(iraw_ff & imask_ff);
            OFF_ALTSEL:  rdata = DATA_W'(alt_function_select_ff);
            OFF_PULLDN:  rdata = DATA_W'(pull_down_enable_ff);
            OFF_PULLUP:  rdata = DATA_W'(pull_up_enable_ff);
            OFF_DIGEN:   rdata = DATA_W'(digital_enable_reg_ff);
            OFF_MUXCTL:  rdata = DATA_W'(port_mux_control_ff);
            default:     rdata = '0;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_masked_write: assert property ( // RQ8
      data_wr |=> ((pin_data_reg_ff ^ $past(pin_data_reg_ff)) & $past(direction_reg_ff & ~wmask)) == '0)
      else $error("Masked data bits changed on write.");

   chk_masked_read: assert property ( // RQ7
      (rd_off[11:10] == DATA_REGION) |-> (rdata[WIDTH-1:0] & ~rmask) == '0)
      else $error("Masked-off data bits read non-zero.");

   chk_edge_sticky: assert property ( // RQ18
      ##1 (($past(iraw_ff & ~isense_ff & ~clr) & ~isense_ff & ~iraw_ff) == '0))
      else $error("Edge interrupt lost without a clear.");

   chk_rise_seen: assert property ( // RQ5
      (|(rise & digital_enable_reg_ff & ~isense_ff & ~iboth_ff & ievent_ff))
      |=> ((iraw_ff & $past(rise & digital_enable_reg_ff & ~isense_ff & ~iboth_ff & ievent_ff))
           == $past(rise & digital_enable_reg_ff & ~isense_ff & ~iboth_ff & ievent_ff)))
      else $error("Rising edge not flagged.");

   chk_level_track: assert property ( // RQ6
      ##1 (((iraw_ff ^ $past(sync_ff ~^ ievent_ff)) & $past(isense_ff & digital_enable_reg_ff)) == '0))
      else $error("Level interrupt does not follow the pin.");

   chk_irq_masked: assert property ( // RQ4
      (imask_ff == '0) |=> !irq_ff)
      else $error("Interrupt raised while all pins masked.");

   chk_digen_off: assert property ( // RQ9
      ##1 (((pad_oe_ff | alt_in_ff) & ~$past(digital_enable_reg_ff)) == '0))
      else $error("Disabled pin still active.");

   chk_alt_drive: assert property ( // RQ10
      hresetn |=> (((pad_out_ff ^ $past(alt_out)) & $past(alt_function_select_ff)) == '0))
      else $error("Alternate pin not driven by peripheral.");

   chk_dir_drive: assert property ( // RQ17
      ##1 (((pad_oe_ff ^ $past(digital_enable_reg_ff))
            & $past(direction_reg_ff & ~alt_function_select_ff)) == '0))
      else $error("Output pin not enabled.");

   chk_input_sync: assert property ( // RQ19
      hresetn |-> ##3 (((pin_data_reg_ff ^ $past(pad_in, 3))
            & $past(~direction_reg_ff & digital_enable_reg_ff) & $past(~direction_reg_ff, 2)
            & $past(pad_in, 3) & $past(pad_in, 4)) == '0))
      else $error("Input capture not two stages late.");

endmodule : gpio_port

module gpio_ports_with_pin_mux
   import gpio_pkg::*;
(
   // Clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // AHB-Lite slave
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [DATA_W-1:0]      hwdata,
   output logic      [DATA_W-1:0]      hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // Port A pins and peripherals
   input  wire logic [WIDTH_A-1:0]     pad_in_a,
   output logic      [WIDTH_A-1:0]     pad_out_a,
   output logic      [WIDTH_A-1:0]     pad_oe_a,
   output logic      [WIDTH_A-1:0]     pull_up_a,
   output logic      [WIDTH_A-1:0]     pull_down_a,
   output logic      [WIDTH_A-1:0]     dig_en_a,
   input  wire logic [WIDTH_A-1:0]     alt_out_a,
   input  wire logic [WIDTH_A-1:0]     alt_oe_a,
   output logic      [WIDTH_A-1:0]     alt_in_a,
   output logic      [4*WIDTH_A-1:0]   mux_code_a,
   output logic                        irq_a,
   // Port B pins and peripherals
   input  wire logic [WIDTH_B-1:0]     pad_in_b,
   output logic      [WIDTH_B-1:0]     pad_out_b,
   output logic      [WIDTH_B-1:0]     pad_oe_b,
   output logic      [WIDTH_B-1:0]     pull_up_b,
   output logic      [WIDTH_B-1:0]     pull_down_b,
   output logic      [WIDTH_B-1:0]     dig_en_b,
   input  wire logic [WIDTH_B-1:0]     alt_out_b,
   input  wire logic [WIDTH_B-1:0]     alt_oe_b,
   output logic      [WIDTH_B-1:0]     alt_in_b,
   output logic      [4*WIDTH_B-1:0]   mux_code_b,
   output logic                        irq_b,
   // Port C pins and peripherals
   input  wire logic [WIDTH_C-1:0]     pad_in_c,
   output logic      [WIDTH_C-1:0]     pad_out_c,
   output logic      [WIDTH_C-1:0]     pad_oe_c,
   output logic      [WIDTH_C-1:0]     pull_up_c,
   output logic      [WIDTH_C-1:0]     pull_down_c,
   output logic      [WIDTH_C-1:0]     dig_en_c,
   input  wire logic [WIDTH_C-1:0]     alt_out_c,
   input  wire logic [WIDTH_C-1:0]     alt_oe_c,
   output logic      [WIDTH_C-1:0]     alt_in_c,
   output logic      [4*WIDTH_C-1:0]   mux_code_c,
   output logic                        irq_c
);

   // ****************************************
   // Bus slave
   // ****************************************
   // One wait state per transfer lets read data leave from a flop; pipelined
   // writes still land every two clocks.
   bus_state_t        state_ff;
   logic [13:0]       addr_ff;
   logic              write_ff, hreadyout_ff, hresp_ff;
   logic [DATA_W-1:0] hrdata_ff, rdata_a, rdata_b, rdata_c;
   reg_wr_t           wr_a, wr_b, wr_c;

   // (RQ3) Data phase of two cycles.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff     <= ST_IDLE;
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
         addr_ff      <= '0;
         write_ff     <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (htrans[1]) begin
                  state_ff     <= ST_DATA;
                  hreadyout_ff <= 1'b0;
                  addr_ff      <= haddr[13:0];
                  write_ff     <= hwrite;
               end
            end
            ST_DATA: begin
               state_ff     <= ST_IDLE;
               hreadyout_ff <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      wr_a      = '{en: 1'b0, off: addr_ff[11:0], data: hwdata};
      wr_b      = wr_a;
      wr_c      = wr_a;
      wr_a.en   = (state_ff == ST_DATA) && write_ff && (addr_ff[13:12] == SEL_PORT_A);
      wr_b.en   = (state_ff == ST_DATA) && write_ff && (addr_ff[13:12] == SEL_PORT_B);
      wr_c.en   = (state_ff == ST_DATA) && write_ff && (addr_ff[13:12] == SEL_PORT_C);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= '0;
      end else if ((state_ff == ST_DATA) && !write_ff) begin
         unique case (addr_ff[13:12])
            SEL_PORT_A: hrdata_ff <= rdata_a;
            SEL_PORT_B: hrdata_ff <= rdata_b;
            SEL_PORT_C: hrdata_ff <= rdata_c;
            default:    hrdata_ff <= '0;
         endcase
      end
   end

   assign hrdata    = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp     = hresp_ff;

   // ****************************************
   // Ports
   // ****************************************
   // (RQ1) Three identical instances; (RQ2) widths six, eight, four.
   // (RQ14) Port A defaults to serial functions, code one.
   gpio_port #(.WIDTH(WIDTH_A), .ALT_RST(RST_A_ALT), .DIGEN_RST(RST_A_DIGEN), .PULLD_RST(RST_A_PULL),
               .PULLU_RST(RST_A_PULL), .MUX_RST(RST_A_MUX)) u_port_a (
      .hclk(hclk), .hresetn(hresetn), .wr(wr_a), .rd_off(addr_ff[11:0]), .rdata(rdata_a),
      .pad_in(pad_in_a), .pad_out_ff(pad_out_a), .pad_oe_ff(pad_oe_a),
      .pull_up_enable_ff(pull_up_a), .pull_down_enable_ff(pull_down_a), .digital_enable_reg_ff(dig_en_a),
      .alt_out(alt_out_a), .alt_oe(alt_oe_a), .alt_in_ff(alt_in_a),
      .port_mux_control_ff(mux_code_a), .irq_ff(irq_a));

   // (RQ12) Port B resets to plain tri-stated pins.
   gpio_port #(.WIDTH(WIDTH_B), .ALT_RST(RST_B_ZERO), .DIGEN_RST(RST_B_ZERO), .PULLD_RST(RST_B_ZERO),
               .PULLU_RST(RST_B_ZERO), .MUX_RST(RST_B_MUX)) u_port_b (
      .hclk(hclk), .hresetn(hresetn), .wr(wr_b), .rd_off(addr_ff[11:0]), .rdata(rdata_b),
      .pad_in(pad_in_b), .pad_out_ff(pad_out_b), .pad_oe_ff(pad_oe_b),
      .pull_up_enable_ff(pull_up_b), .pull_down_enable_ff(pull_down_b), .digital_enable_reg_ff(dig_en_b),
      .alt_out(alt_out_b), .alt_oe(alt_oe_b), .alt_in_ff(alt_in_b),
      .port_mux_control_ff(mux_code_b), .irq_ff(irq_b));

   // (RQ15) Port C defaults to debug pins with pull-ups, code three.
   gpio_port #(.WIDTH(WIDTH_C), .ALT_RST(RST_C_ALT), .DIGEN_RST(RST_C_DIGEN), .PULLD_RST(RST_C_PULLD),
               .PULLU_RST(RST_C_PULLU), .MUX_RST(RST_C_MUX)) u_port_c (
      .hclk(hclk), .hresetn(hresetn), .wr(wr_c), .rd_off(addr_ff[11:0]), .rdata(rdata_c),
      .pad_in(pad_in_c), .pad_out_ff(pad_out_c), .pad_oe_ff(pad_oe_c),
      .pull_up_enable_ff(pull_up_c), .pull_down_enable_ff(pull_down_c), .digital_enable_reg_ff(dig_en_c),
      .alt_out(alt_out_c), .alt_oe(alt_oe_c), .alt_in_ff(alt_in_c),
      .port_mux_control_ff(mux_code_c), .irq_ff(irq_c));

   // (RQ16) Peripheral wiring per pin lives outside, selected by the mux codes.

endmodule : gpio_ports_with_pin_mux

`default_nettype wire

// ==== verification/pin_model.sv ====
// Pin and peripheral model for one port of the pin block.
`timescale 1ns/10ps
`default_nettype none

module pin_model #(
   parameter int W = 8
) (
   // Pin side
   input  wire logic [W-1:0] pad_out,
   input  wire logic [W-1:0] pad_oe,
   input  wire logic [W-1:0] ext,
   output logic      [W-1:0] pad_in,
   // Peripheral side
   input  wire logic [W-1:0] alt_val,
   output logic      [W-1:0] alt_out,
   output logic      [W-1:0] alt_oe
);
   // wire level
   // A driven pin shows the device's value, so an outside source never fights it here.
   assign pad_in  = (pad_oe & pad_out) | (~pad_oe & ext);
   assign alt_out = alt_val;
   assign alt_oe  = '1;
endmodule : pin_model

`default_nettype wire

// ==== verification/tb_gpio_ports_with_pin_mux.sv ====
// Self-checking bench for the three-port pin block.
`timescale 1ns/10ps
`default_nettype none

module tb_gpio_ports_with_pin_mux
   import gpio_pkg::*;
;
   logic                 hclk, hresetn, hwrite, hreadyout, hresp, irq_a, irq_b, irq_c;
   logic [31:0]          haddr, hwdata, hrdata, rd;
   logic [1:0]           htrans;
   logic [2:0]           hsize;
   logic [3:0]           m;
   logic [WIDTH_A-1:0]   pad_in_a, pad_out_a, pad_oe_a, pull_up_a, pull_down_a, dig_en_a, alt_out_a, alt_oe_a;
   logic [WIDTH_A-1:0]   alt_in_a, ext_a, alt_val_a;
   logic [WIDTH_B-1:0]   pad_in_b, pad_out_b, pad_oe_b, pull_up_b, pull_down_b, dig_en_b, alt_out_b, alt_oe_b;
   logic [WIDTH_B-1:0]   alt_in_b, ext_b, alt_val_b;
   logic [WIDTH_C-1:0]   pad_in_c, pad_out_c, pad_oe_c, pull_up_c, pull_down_c, dig_en_c, alt_out_c, alt_oe_c;
   logic [WIDTH_C-1:0]   alt_in_c, ext_c, alt_val_c;
   logic [4*WIDTH_A-1:0] mux_code_a;
   logic [4*WIDTH_B-1:0] mux_code_b;
   logic [4*WIDTH_C-1:0] mux_code_c;
   int                   fail_count, num_checks;
   int                   cycles = 0;
   // Interrupt modes as sense, both, event, active pin level.
   localparam logic [3:0] MODES [5] = '{4'h3, 4'h0, 4'h4, 4'hB, 4'h8};

   gpio_ports_with_pin_mux i_gpio_ports_with_pin_mux (
      .hclk, .hresetn, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata, .hreadyout, .hresp,
      .pad_in_a, .pad_out_a, .pad_oe_a, .pull_up_a, .pull_down_a, .dig_en_a, .alt_out_a, .alt_oe_a,
      .alt_in_a, .mux_code_a, .irq_a,
      .pad_in_b, .pad_out_b, .pad_oe_b, .pull_up_b, .pull_down_b, .dig_en_b, .alt_out_b, .alt_oe_b,
      .alt_in_b, .mux_code_b, .irq_b,
      .pad_in_c, .pad_out_c, .pad_oe_c, .pull_up_c, .pull_down_c, .dig_en_c, .alt_out_c, .alt_oe_c,
      .alt_in_c, .mux_code_c, .irq_c);
   pin_model #(.W(WIDTH_A)) i_pin_model_a (.pad_out(pad_out_a), .pad_oe(pad_oe_a), .ext(ext_a),
      .pad_in(pad_in_a), .alt_val(alt_val_a), .alt_out(alt_out_a), .alt_oe(alt_oe_a));
   pin_model #(.W(WIDTH_B)) i_pin_model_b (.pad_out(pad_out_b), .pad_oe(pad_oe_b), .ext(ext_b),
      .pad_in(pad_in_b), .alt_val(alt_val_b), .alt_out(alt_out_b), .alt_oe(alt_oe_b));
   pin_model #(.W(WIDTH_C)) i_pin_model_c (.pad_out(pad_out_c), .pad_oe(pad_oe_c), .ext(ext_c),
      .pad_in(pad_in_c), .alt_val(alt_val_c), .alt_out(alt_out_c), .alt_oe(alt_oe_c));

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Hold each phase until hready is sampled high; the slave's wait state length is not assumed.
   task automatic xfer(input logic w, input logic [1:0] p, input logic [11:0] o, input logic [31:0] d);
      @(posedge hclk);
      haddr  <= {18'h0, p, o};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task automatic rc(input logic [1:0] p, input logic [11:0] o, input logic [31:0] e);
      xfer(1'b0, p, o, 32'h0);
      chk("hrdata", rd, e);
   endtask : rc

   task automatic look(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask : look

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end

   initial begin
      {hresetn, haddr, htrans, hwrite, hwdata, fail_count, num_checks} = '0;
      hsize = 3'h2;
      {ext_a, ext_b, ext_c, alt_val_a, alt_val_b, alt_val_c} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rc(SEL_PORT_A, OFF_ALTSEL, 32'h3F);
      rc(SEL_PORT_A, OFF_MUXCTL, 32'h111111);
      rc(SEL_PORT_C, OFF_MUXCTL, 32'h3333);
      rc(SEL_PORT_C, OFF_PULLUP, 32'hF);
      rc(SEL_PORT_B, OFF_DIGEN, 32'h0);
      rc(2'h3, OFF_DIR, 32'h0);
      chk("pad_oe_b", 32'(pad_oe_b), 32'h0);
      chk("dig_en_c", 32'(dig_en_c), 32'hF);
      chk("pads_a", 32'({pull_up_a, pull_down_a, dig_en_a}), 32'h3F);
      chk("pads_b", 32'({pull_up_b, pull_down_b, dig_en_b}), 32'h0);
      chk("pads_c", 32'({pull_up_c, pull_down_c, dig_en_c}), 32'hF0F);
      chk("mux_a", 32'(mux_code_a), 32'h111111);
      chk("mux_b", mux_code_b, 32'h0);
      chk("mux_c", 32'(mux_code_c), 32'h3333);
      xfer(1'b1, SEL_PORT_B, OFF_DIR, 32'hFF);
      xfer(1'b1, SEL_PORT_B, OFF_DIGEN, 32'hFF);
      xfer(1'b1, SEL_PORT_B, 12'h098, 32'hEB);
      look(0);
      chk("pad_out_b", 32'(pad_out_b), 32'h22);
      chk("pad_oe_b", 32'(pad_oe_b), 32'hFF);
      xfer(1'b1, SEL_PORT_B, 12'h3FC, 32'h5A);
      xfer(1'b1, SEL_PORT_B, 12'h3FC, 32'hA5);
      look(0);
      chk("pad_out_b", 32'(pad_out_b), 32'hA5);
      rc(SEL_PORT_B, 12'h0C4, 32'h21);
      xfer(1'b1, SEL_PORT_B, OFF_DIR, 32'h0);
      ext_b <= 8'hC3;
      look(6);
      rc(SEL_PORT_B, 12'h3FC, 32'hC3);
      xfer(1'b1, SEL_PORT_B, OFF_DIGEN, 32'h0F);
      rc(SEL_PORT_B, 12'h3FC, 32'h03);
      xfer(1'b1, SEL_PORT_B, OFF_DIGEN, 32'hFF);
      for (int i = 0; i < 5; i++) begin
         m = MODES[i];
         xfer(1'b1, SEL_PORT_B, OFF_IMASK, 32'h0);
         ext_b <= {7'h0, ~m[0]};
         xfer(1'b1, SEL_PORT_B, OFF_ISENSE, {31'h0, m[3]});
         xfer(1'b1, SEL_PORT_B, OFF_IBOTH, {31'h0, m[2]});
         xfer(1'b1, SEL_PORT_B, OFF_IEVENT, {31'h0, m[1]});
         look(6);
         xfer(1'b1, SEL_PORT_B, OFF_ICLEAR, 32'hFF);
         xfer(1'b1, SEL_PORT_B, OFF_IMASK, 32'h1);
         look(1);
         chk("irq_b idle", 32'(irq_b), 32'h0);
         @(posedge hclk);
         ext_b <= {7'h0, m[0]};
         look(6);
         chk("irq_b", 32'(irq_b), 32'h1);
         rc(SEL_PORT_B, OFF_IRAW, 32'h1);
         rc(SEL_PORT_B, OFF_IMASKED, 32'h1);
         xfer(1'b1, SEL_PORT_B, OFF_ICLEAR, 32'h1);
         look(1);
         chk("irq_b clear", 32'(irq_b), {31'h0, m[3]});
      end
      xfer(1'b1, SEL_PORT_B, OFF_IMASK, 32'h0);
      look(1);
      chk("irq_b masked", 32'(irq_b), 32'h0);
      alt_val_a <= 6'h2A;
      alt_val_c <= 4'h5;
      look(4);
      chk("pad_out_a", 32'(pad_out_a), 32'h2A);
      chk("alt_in_a", 32'(alt_in_a), 32'h2A);
      chk("pad_out_c", 32'(pad_out_c), 32'h5);
      chk("alt_in_c", 32'(alt_in_c), 32'h5);
      chk("alt_in_b", 32'(alt_in_b), 32'h0);
      chk("irq_a_c", 32'({irq_a, irq_c}), 32'h0);
      xfer(1'b1, SEL_PORT_A, OFF_DIGEN, 32'h3E);
      look(1);
      chk("pad_oe_a", 32'(pad_oe_a), 32'h3E);
      xfer(1'b1, SEL_PORT_A, OFF_MUXCTL, 32'h111511);
      chk("mux_a", 32'(mux_code_a), 32'h111511);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rc(SEL_PORT_A, OFF_DIGEN, 32'h3F);
      rc(SEL_PORT_B, OFF_DIR, 32'h0);
      chk("mux_a", 32'(mux_code_a), 32'h111111);
      summarize();
   end
endmodule : tb_gpio_ports_with_pin_mux

`default_nettype wire
